//--- hw/apc_ctrl.sv
// module: controller end issuing commands under per-bank countdowns
`timescale 1ns/1ns
module apc_ctrl (
   apc_if.ctrl        link,        // command link
   input  wire logic       req_valid, // user command request
   input  wire logic [3:0] req_cmd,   // command code
   input  wire logic [2:0] req_bank,  // bank
   input  wire logic       req_all,   // all-bank precharge
   input  wire logic       req_ap,    // auto close on read/write
   output logic       req_ready    // request legal this cycle, whether or not req_valid is high
);
   // ------------------------------------------------------------------
   // per-bank countdowns
   // ------------------------------------------------------------------
   logic [apc_pkg::CW-1:0] pre_wait [8];   // until precharge allowed
   logic [apc_pkg::CW-1:0] act_wait [8];   // until activate allowed
   logic [apc_pkg::CW-1:0] rc_wait  [8];   // row cycle since activate
   logic [7:0]             opened;         // row open
   logic [7:0]             ap_lock;        // auto close burst in flight
   logic [apc_pkg::CW-1:0] rd_wait, wr_wait, pp_wait;   // global spacing
   logic [2:0]             last_bank;      // bank of latest read/write
   logic                   last_wr;        // latest burst was a write

   logic ok, is_pre, is_act, is_rd, is_wr, is_bst;
   assign is_pre = req_cmd == apc_pkg::CMD_PRE;
   assign is_act = req_cmd == apc_pkg::CMD_ACT;
   assign is_rd  = req_cmd == apc_pkg::CMD_RD;
   assign is_wr  = req_cmd == apc_pkg::CMD_WR;
   assign is_bst = req_cmd == apc_pkg::CMD_BST;

   // legality: block anything inside a window
   always_comb begin
      ok = 1'b1;
      if (is_pre) begin
         ok = pp_wait == '0;
         for (int i = 0; i < 8; i++) begin
            if ((req_all || req_bank == 3'(i)) && (pre_wait[i] != '0 || ap_lock[i])) begin
               ok = 1'b0;
            end
         end
      end else if (is_act) begin
         ok = !opened[req_bank] && act_wait[req_bank] == '0 && rc_wait[req_bank] == '0;
      end else if (is_rd || is_wr) begin
         ok = opened[req_bank] && !ap_lock[req_bank]
              && (is_rd ? rd_wait == '0 : wr_wait == '0);
      end else if (is_bst) begin
         ok = !ap_lock[last_bank];
      end
   end
   assign req_ready = ok;
   logic fire;
   assign fire = req_valid && ok;

   // command pins registered
   always_ff @(posedge link.clock or negedge link.rstn) begin
      if (!link.rstn) begin
         link.cs_n <= 1'b1;
         link.cmd <= apc_pkg::CMD_NOP;
         link.all_bank <= 1'b0;
         link.bank <= 3'h0;
         link.auto_close_flag <= 1'b0;
      end else begin
         link.cs_n <= !fire;
         link.cmd <= fire ? req_cmd : apc_pkg::CMD_NOP;
         link.all_bank <= fire && req_all;
         link.bank <= req_bank;
         link.auto_close_flag <= fire && req_ap && (is_rd || is_wr);
      end
   end

   // global spacing counters
   always_ff @(posedge link.clock or negedge link.rstn) begin
      if (!link.rstn) begin
         rd_wait <= '0;
         wr_wait <= '0;
         pp_wait <= '0;
         last_bank <= 3'h0;
         last_wr <= 1'b0;
      end else begin
         rd_wait <= (rd_wait != '0) ? rd_wait - 1'b1 : '0;
         wr_wait <= (wr_wait != '0) ? wr_wait - 1'b1 : '0;
         pp_wait <= (pp_wait != '0) ? pp_wait - 1'b1 : '0;
         if (fire && is_pre) begin
            pp_wait <= apc_pkg::CW'(apc_pkg::PRE_PRE - 1);
         end
         if (fire && is_rd) begin
            last_bank <= req_bank;
            last_wr <= 1'b0;
            rd_wait <= apc_pkg::CW'(apc_pkg::CCD - 1);
            wr_wait <= apc_pkg::CW'(apc_pkg::RDAP_WR - 1);
         end
         if (fire && is_wr) begin
            last_bank <= req_bank;
            last_wr <= 1'b1;
            wr_wait <= apc_pkg::CW'(apc_pkg::CCD - 1);
            rd_wait <= apc_pkg::CW'(apc_pkg::WRAP_RD - 1);
         end
      end
   end

   // per-bank countdowns
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_bank
         logic hit;
         assign hit = req_bank == 3'(g);
         always_ff @(posedge link.clock or negedge link.rstn) begin
            if (!link.rstn) begin
               pre_wait[g] <= '0;
               act_wait[g] <= '0;
               rc_wait[g] <= '0;
               opened[g] <= 1'b0;
               ap_lock[g] <= 1'b0;
            end else begin
               pre_wait[g] <= (pre_wait[g] != '0) ? pre_wait[g] - 1'b1 : '0;
               act_wait[g] <= (act_wait[g] != '0) ? act_wait[g] - 1'b1 : '0;
               rc_wait[g]  <= (rc_wait[g]  != '0) ? rc_wait[g]  - 1'b1 : '0;
               if (ap_lock[g] && pre_wait[g] <= 6'h1) begin
                  ap_lock[g] <= 1'b0;
                  opened[g]  <= 1'b0;
               end
               if (fire && is_act && hit) begin
                  opened[g]  <= 1'b1;
                  rc_wait[g] <= apc_pkg::CW'(apc_pkg::RC_CK - 1);
               end else if (fire && is_pre && (req_all || hit)) begin
                  opened[g]   <= 1'b0;
                  act_wait[g] <= req_all ? apc_pkg::CW'(apc_pkg::RPAB_CK - 1)
                                         : apc_pkg::CW'(apc_pkg::RP_CK - 1);
               end else if (fire && (is_rd || is_wr) && hit) begin
                  pre_wait[g] <= is_rd ? apc_pkg::CW'(apc_pkg::RD_PRE - 1)
                                       : apc_pkg::CW'(apc_pkg::WR_PRE - 1);
                  if (req_ap) begin
                     ap_lock[g]  <= 1'b1;
                     act_wait[g] <= is_rd ? apc_pkg::CW'(apc_pkg::RD_PRE + apc_pkg::RP_CK - 1)
                                          : apc_pkg::CW'(apc_pkg::WR_PRE + apc_pkg::RP_CK - 1);
                  end
               end else if (fire && is_bst && last_wr && last_bank == 3'(g)) begin
                  pre_wait[g] <= apc_pkg::CW'(apc_pkg::BSTW_PRE - 1);
               end
            end
         end
      end
   endgenerate
endmodule : apc_ctrl

//--- hw/apc_pkg.sv
// package: constants shared by both ends of the auto-close timing link
package apc_pkg;
   // ------------------------------------------------------------------
   // command codes on the four command bits, rising half
   // ------------------------------------------------------------------
   localparam logic [3:0] CMD_PRE    = 4'hb;   // bits 0..3 = h,h,l,h
   localparam logic [3:0] CMD_BST    = 4'h3;   // bits 0..3 = h,h,l,l
   localparam logic [3:0] CMD_ACT    = 4'h0;   // activate code (bit0,bit1 low)
   localparam logic [3:0] CMD_WR     = 4'h1;   // write code
   localparam logic [3:0] CMD_RD     = 4'h5;   // read code
   localparam logic [3:0] CMD_NOP    = 4'h7;   // no operation
   // ------------------------------------------------------------------
   // geometry and timing
   // ------------------------------------------------------------------
   localparam int         NBANK      = 8;
   localparam int         BL         = 8;      // burst length from mode register
   localparam int         RL         = 6;      // read latency, clocks
   localparam int         WL         = 3;      // write latency, clocks
   localparam int         CLK_NS     = 10;     // clock period
   localparam int         T_RTP_NS   = 8;      // read to precharge
   localparam int         T_RP_NS    = 18;     // single-bank row precharge
   localparam int         T_RPAB_NS  = 21;     // all-bank row precharge
   localparam int         T_WR_NS    = 15;     // write recovery
   localparam int         T_WTR_NS   = 8;      // write to read
   localparam int         T_RC_NS    = 60;     // row cycle
   localparam int         T_DQSCK_NS = 6;      // max strobe access
   localparam int         PREFETCH   = 4;      // write data group size
   // least times round up
   localparam int         RTP_CK     = (T_RTP_NS + CLK_NS - 1) / CLK_NS;
   localparam int         RP_CK      = (T_RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int         RPAB_CK    = (T_RPAB_NS + CLK_NS - 1) / CLK_NS;
   localparam int         WR_CK      = (T_WR_NS + CLK_NS - 1) / CLK_NS;
   localparam int         WTR_CK     = (T_WTR_NS + CLK_NS - 1) / CLK_NS;
   localparam int         RC_CK      = (T_RC_NS + CLK_NS - 1) / CLK_NS;
   localparam int         DQSCK_CK   = (T_DQSCK_NS + CLK_NS - 1) / CLK_NS;
   // derived separations
   localparam int         RD_PRE     = BL/2 + ((RTP_CK > 2) ? RTP_CK : 2) - 2;
   localparam int         RDAP_START = (BL/2 > BL/2 - 2 + RTP_CK) ? BL/2 : BL/2 - 2 + RTP_CK;
   localparam int         WR_PRE     = WL + BL/2 + WR_CK + 1;
   localparam int         BSTW_PRE   = WL + WR_CK + 1;
   localparam int         RDAP_WR    = RL + BL/2 + DQSCK_CK - WL + 1;
   localparam int         WRAP_RD    = WL + BL/2 + WTR_CK + 1;
   localparam int         CCD        = BL/2;
   localparam int         PRE_PRE    = 1;
   localparam int         CW         = 6;      // countdown width
endpackage : apc_pkg

//--- hw/apc_if.sv
// interface: command/address link between controller and memory end
`timescale 1ns/1ns
interface apc_if (
   input wire logic clock,
   input wire logic rstn
);
   logic       cs_n;      // chip select, active low
   logic [3:0] cmd;       // command bits 0..3, rising half
   logic       all_bank;  // all-bank flag for precharge
   logic [2:0] bank;      // bank address
   logic       auto_close_flag; // falling-half bit 0 of read/write
   modport ctrl (input clock, input rstn, output cs_n, output cmd, output all_bank,
                 output bank, output auto_close_flag);
   modport mem  (input clock, input rstn, input cs_n, input cmd, input all_bank,
                 input bank, input auto_close_flag);
endinterface : apc_if

//--- hw/apc_mem.sv
// module: memory-side bank open/close and auto precharge tracking
`timescale 1ns/1ns
// Function
// - controller closes bank before new row
// - flag low keeps bank open
// - flag high on read engages auto close
// - read auto close starts at greater delay
// - read to precharge wait
// - read-ap to activate wait
// - no read/write to auto-closing bank
// - other-bank same-type spacing BL/2
// - read-ap to other-bank write spacing
// - write to precharge wait
// - terminate-write to precharge wait
// - write-ap precharge and activate waits
// - precharges one clock apart
// - precharge period from latest precharge
// - commands inside windows are illegal
// - auto close bursts never interrupted
// - activate needs tRP and tRC
// - write recovery from last data
// - array writes in groups of four
// - precharge code h,h,l,h plus all-bank flag
module apc_mem (
   apc_if.mem                 link,            // command link
   output logic [7:0]         bank_open,       // bank holds an open row
   output logic [7:0]         bank_closing,    // auto close pending
   output logic [7:0]         bank_precharging,// precharge period running
   output logic               array_write      // internal array write group start
);
   // ------------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------------
   // link pins come from the other party's logic on the same clock
   logic is_cmd;
   assign is_cmd = !link.cs_n;

   // bank mask of a precharge: one bank or all
   function automatic logic [7:0] pre_mask(input logic ab, input logic [2:0] b);
      pre_mask = ab ? 8'hff : (8'h01 << b);
   endfunction : pre_mask

   // banks reached by a precharge: one or all
   logic [7:0] pre_hit;
   assign pre_hit = pre_mask(link.all_bank, link.bank);

   // one strobe per command code
   logic is_pre, is_act, is_rd, is_wr, is_bst;
   assign is_pre = is_cmd && link.cmd == apc_pkg::CMD_PRE;
   assign is_act = is_cmd && link.cmd == apc_pkg::CMD_ACT;
   assign is_rd  = is_cmd && link.cmd == apc_pkg::CMD_RD;
   assign is_wr  = is_cmd && link.cmd == apc_pkg::CMD_WR;
   assign is_bst = is_cmd && link.cmd == apc_pkg::CMD_BST;

   // ------------------------------------------------------------------
   // per-bank state
   // ------------------------------------------------------------------
   logic [apc_pkg::CW-1:0] close_cnt [8];   // clocks until auto close starts
   logic [apc_pkg::CW-1:0] pre_cnt   [8];   // clocks left of precharge period

   genvar g;
   generate
      for (g = 0; g < apc_pkg::NBANK; g++) begin : g_bank
         logic hit;
         assign hit = link.bank == 3'(g);
         // open flag: set on activate, cleared when precharge starts
         always_ff @(posedge link.clock or negedge link.rstn) begin
            if (!link.rstn) begin
               bank_open[g] <= 1'b0;
            end else if (is_act && hit) begin
               // activate opens a row
               bank_open[g] <= 1'b1;
            end else if (is_pre && pre_hit[g]) begin
               // explicit precharge closes it
               bank_open[g] <= 1'b0;
            end else if (bank_closing[g] && close_cnt[g] == '0) begin
               bank_open[g] <= 1'b0;
            end
         end
         // auto close countdown, armed only when flag high
         always_ff @(posedge link.clock or negedge link.rstn) begin
            if (!link.rstn) begin
               bank_closing[g] <= 1'b0;
               close_cnt[g]    <= '0;
            end else if ((is_rd || is_wr) && hit && link.auto_close_flag) begin
               bank_closing[g] <= 1'b1;
               close_cnt[g]    <= is_rd ? apc_pkg::CW'(apc_pkg::RDAP_START - 1)
                                        : apc_pkg::CW'(apc_pkg::WR_PRE - 1);
            end else if (bank_closing[g]) begin
               // flag low never arms this, so such a bank stays open
               if (close_cnt[g] == '0) begin
                  // count spent: precharge starts at this edge
                  bank_closing[g] <= 1'b0;
               end else begin
                  close_cnt[g] <= close_cnt[g] - 1'b1;
               end
            end
         end
         // precharge period restarts from the latest precharge reaching the bank
         always_ff @(posedge link.clock or negedge link.rstn) begin
            if (!link.rstn) begin
               pre_cnt[g] <= '0;
            end else if (is_pre && pre_hit[g]) begin
               // all-bank precharge takes the longer period
               pre_cnt[g] <= link.all_bank ? apc_pkg::CW'(apc_pkg::RPAB_CK)
                                           : apc_pkg::CW'(apc_pkg::RP_CK);
            end else if (bank_closing[g] && close_cnt[g] == '0) begin
               pre_cnt[g] <= apc_pkg::CW'(apc_pkg::RP_CK);
            end else if (pre_cnt[g] != '0) begin
               pre_cnt[g] <= pre_cnt[g] - 1'b1;
            end
         end
         assign bank_precharging[g] = pre_cnt[g] != '0;
      end
   endgenerate

   // ------------------------------------------------------------------
   // write prefetch grouping: an array write starts per four-word group
   // ------------------------------------------------------------------
   logic [apc_pkg::CW-1:0] wdata_cnt;   // data-beat clocks left in burst
   logic [apc_pkg::CW-1:0] wlat_cnt;    // clocks until data begins
   logic                   wpend;       // write awaiting its data
   always_ff @(posedge link.clock or negedge link.rstn) begin
      if (!link.rstn) begin
         wpend     <= 1'b0;
         wlat_cnt  <= '0;
         wdata_cnt <= '0;
      end else if (is_wr) begin
         wpend     <= 1'b1;
         wlat_cnt  <= apc_pkg::CW'(apc_pkg::WL);
         wdata_cnt <= apc_pkg::CW'(apc_pkg::BL/2);
      end else if (is_bst) begin
         wdata_cnt <= '0;                         // truncated to latched groups
         wpend     <= 1'b0;
      end else if (wpend && wlat_cnt != '0) begin
         wlat_cnt <= wlat_cnt - 1'b1;
      end else if (wpend && wdata_cnt != '0) begin
         wdata_cnt <= wdata_cnt - 1'b1;
         if (wdata_cnt == 6'h1) begin
            wpend <= 1'b0;
         end
      end
   end
   // two data beats per clock: a full group of four is latched every second clock
   always_ff @(posedge link.clock or negedge link.rstn) begin
      if (!link.rstn) begin
         array_write <= 1'b0;
      end else begin
         array_write <= wpend && wlat_cnt == '0 && wdata_cnt != '0
                        && wdata_cnt[0] == 1'b1 && (apc_pkg::PREFETCH == 4);
      end
   end
endmodule : apc_mem

//--- testbench/apc_properties.sv
// checker: command spacing and bank state on the link between both ends
`timescale 1ns/1ns
module apc_properties (
   input wire logic       clock,           // link clock
   input wire logic       rstn,            // async reset, active low
   input wire logic       cs_n,            // chip select, active low
   input wire logic [3:0] cmd,             // command code
   input wire logic       all_bank,        // all-bank precharge flag
   input wire logic [2:0] bank,            // bank address
   input wire logic       auto_close_flag  // auto close on read/write
);
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   wire act = !cs_n && (cmd == apc_pkg::CMD_ACT);  // activate
   wire rd  = !cs_n && (cmd == apc_pkg::CMD_RD);   // read
   wire wr  = !cs_n && (cmd == apc_pkg::CMD_WR);   // write
   wire pre = !cs_n && (cmd == apc_pkg::CMD_PRE);  // precharge
   wire bst = !cs_n && (cmd == apc_pkg::CMD_BST);  // burst terminate
   wire rap = rd && auto_close_flag;               // read with auto close
   wire wap = wr && auto_close_flag;               // write with auto close
   logic [7:0] open;                               // banks left open
   logic [2:0] rd_bank;                            // bank of latest read
   logic [2:0] wr_bank;                            // bank of latest write
   logic [2:0] ap_bank;                            // bank of latest auto close
   logic [2:0] act_bank;                           // bank of latest activate
   wire pre_rd = pre && (all_bank || bank == rd_bank);
   wire pre_wr = pre && (all_bank || bank == wr_bank);
   wire act_ap = act && (bank == ap_bank);
   // ------------------------------------------------------------
   // helper state: open banks and latest banks of each kind
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         open <= 8'h00;
      end else if (act) begin
         open[bank] <= 1'b1;
      end else if (pre && all_bank) begin
         open <= 8'h00;
      end else if (pre || rap || wap) begin
         open[bank] <= 1'b0;
      end
   end
   // latest bank per command kind
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_bank  <= 3'h0;
         wr_bank  <= 3'h0;
         ap_bank  <= 3'h0;
         act_bank <= 3'h0;
      end else begin
         if (rd) rd_bank <= bank;
         if (wr) wr_bank <= bank;
         if (rap || wap) ap_bank <= bank;
         if (act) act_bank <= bank;
      end
   end
   // ------------------------------------------------------------
   // assertions (spans from package values: 4,4,10,9,9,6,12,6)
   // ------------------------------------------------------------
   act_to_closed_a: assert property (act |-> !open[bank])
      else $error("activate to a bank still open");
   rd_rd_gap_a: assert property (rd |=> !rd [*3])
      else $error("reads closer than burst spacing");
   wr_wr_gap_a: assert property (wr |=> !wr [*3])
      else $error("writes closer than burst spacing");
   rd_pre_gap_a: assert property (rd |=> !pre_rd [*3])
      else $error("precharge too soon after read");
   wr_pre_gap_a: assert property (wr |=> !pre_wr ##1 ((bst ##1 !pre_wr [*5])
      or (!bst && !pre_wr ##1 !pre_wr [*7])))
      else $error("precharge too soon after write");
   rdap_wr_gap_a: assert property (rap |=> !wr [*8])
      else $error("write too soon after auto close read");
   wrap_rd_gap_a: assert property (wap |=> !rd [*8])
      else $error("read too soon after auto close write");
   ap_lock_a: assert property ((rap || wap) |=> !((rd || wr) && bank == ap_bank) [*6])
      else $error("access to a bank under auto close");
   rdap_act_gap_a: assert property (rap |=> !act_ap [*5])
      else $error("activate too soon after auto close read");
   wrap_act_gap_a: assert property (wap |=> !act_ap [*8] ##1 !act_ap ##1 !act_ap ##1 !act_ap)
      else $error("activate too soon after auto close write");
   act_act_gap_a: assert property (act |=> !(act && bank == act_bank) [*5])
      else $error("activate inside row cycle time");
endmodule : apc_properties

//--- testbench/apc_tb_top.sv
// testbench: both link ends joined, driven through the request port
`timescale 1ns/1ns
module apc_tb_top;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic       clock     = 1'b0;               // 100 MHz
   logic       rstn      = 1'b0;               // reset, active low
   logic       req_valid = 1'b0;               // request strobe
   logic [3:0] req_cmd   = apc_pkg::CMD_NOP;   // request code
   logic [2:0] req_bank  = 3'h0;               // request bank
   logic       req_all   = 1'b0;               // all-bank precharge
   logic       req_ap    = 1'b0;               // auto close
   logic       req_ready;                      // request legal
   logic [7:0] bank_open;                      // open banks
   logic [7:0] bank_closing;                   // auto close pending
   logic [7:0] bank_precharging;               // precharge running
   logic       array_write;                    // array group write
   int         fail_count = 0;                 // mismatches
   int         checked    = 0;                 // comparisons
   int         cyc        = 0;                 // cycle count
   int         last_t     = 0;                 // cycle of latest link command
   int         prev_t     = 0;                 // cycle of the one before
   logic [3:0] last_cmd   = 4'h0;              // latest link code
   logic       last_all   = 1'b0;              // latest all-bank flag
   int         aw_count   = 0;                 // array write pulses
   int         k;                              // loop counter
   int         aw0;                            // pulse count snapshot
   always #5 clock = ~clock;
   apc_if i_apc_if (.clock(clock), .rstn(rstn));
   apc_ctrl i_apc_ctrl (.link(i_apc_if), .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
                        .req_all(req_all), .req_ap(req_ap), .req_ready(req_ready));
   apc_mem i_apc_mem (.link(i_apc_if), .bank_open(bank_open), .bank_closing(bank_closing),
                      .bank_precharging(bank_precharging), .array_write(array_write));
   apc_properties i_apc_properties (.clock(clock), .rstn(rstn), .cs_n(i_apc_if.cs_n), .cmd(i_apc_if.cmd),
                                    .all_bank(i_apc_if.all_bank), .bank(i_apc_if.bank),
                                    .auto_close_flag(i_apc_if.auto_close_flag));
   // ------------------------------------------------------------
   // link monitor: stamps each command seen on the wire
   // ------------------------------------------------------------
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (array_write === 1'b1) aw_count <= aw_count + 1;
      if (i_apc_if.cs_n === 1'b0) begin
         prev_t   <= last_t;
         last_t   <= cyc;
         last_cmd <= i_apc_if.cmd;
         last_all <= i_apc_if.all_bank;
      end
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task cmp_vec(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_vec
   // counts and gaps worked out by the bench
   task cmp_num(input int got, input int exp);
      checked++;
      if (got != exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_num
   // wait n edges, then stand just past the edge
   task settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : settle
   // request held until taken; strobe stays up for a following call
   task issue(input logic [3:0] c, input logic [2:0] b, input logic all, input logic ap);
      int n;
      n = 0;
      req_cmd = c;
      req_bank = b;
      req_all = all;
      req_ap = ap;
      req_valid = 1'b1;
      @(negedge clock);
      while (req_ready !== 1'b1 && n < 40) begin
         @(negedge clock);
         n++;
      end
      cmp_vec({7'h0, req_ready}, 8'h01);
      settle(1);
   endtask : issue
   task conclude;
      $display("counts: checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   // ------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------
   initial begin
      #100000;
      fail_count++;
      conclude();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      settle(6);
      rstn = 1'b1;
      cmp_vec({7'h0, i_apc_if.cs_n}, 8'h01);
      cmp_vec({4'h0, i_apc_if.cmd}, {4'h0, apc_pkg::CMD_NOP});
      cmp_vec(bank_open | bank_closing | bank_precharging, 8'h00);
      $display("test reset done");
      // plain read leaves the bank open; precharge spacing after read
      issue(apc_pkg::CMD_ACT, 3'h0, 1'b0, 1'b0);
      issue(apc_pkg::CMD_RD, 3'h0, 1'b0, 1'b0);
      req_valid = 1'b0;
      settle(2);
      cmp_vec(bank_open, 8'h01);
      cmp_vec(bank_closing, 8'h00);
      issue(apc_pkg::CMD_PRE, 3'h0, 1'b0, 1'b0);
      req_valid = 1'b0;
      settle(2);
      cmp_num(last_t - prev_t, apc_pkg::RD_PRE);
      cmp_vec({4'h0, last_cmd}, 8'h0b);
      cmp_vec({7'h0, last_all}, 8'h00);
      cmp_vec(bank_open, 8'h00);
      $display("test read then precharge done");
      // read with auto close: lock, start and precharge period
      issue(apc_pkg::CMD_ACT, 3'h2, 1'b0, 1'b0);
      issue(apc_pkg::CMD_RD, 3'h2, 1'b0, 1'b1);
      req_valid = 1'b0;
      req_ap = 1'b0;
      settle(1);
      cmp_vec(bank_closing, 8'h04);
      cmp_vec({7'h0, req_ready}, 8'h00);
      k = 0;
      while (bank_open[2] === 1'b1 && k < 20) begin
         k++;
         settle(1);
      end
      cmp_num(k, apc_pkg::RDAP_START);
      k = 0;
      while (bank_precharging[2] === 1'b1 && k < 20) begin
         k++;
         settle(1);
      end
      cmp_num(k, apc_pkg::RP_CK);
      $display("test read auto close done");
      // seamless reads to other banks, then write and activate spacing
      issue(apc_pkg::CMD_ACT, 3'h3, 1'b0, 1'b0);
      issue(apc_pkg::CMD_ACT, 3'h4, 1'b0, 1'b0);
      issue(apc_pkg::CMD_ACT, 3'h5, 1'b0, 1'b0);
      issue(apc_pkg::CMD_RD, 3'h3, 1'b0, 1'b1);
      issue(apc_pkg::CMD_RD, 3'h4, 1'b0, 1'b1);
      aw0 = aw_count;
      issue(apc_pkg::CMD_WR, 3'h5, 1'b0, 1'b1);
      cmp_num(last_t - prev_t, apc_pkg::CCD);
      issue(apc_pkg::CMD_ACT, 3'h5, 1'b0, 1'b0);
      cmp_num(last_t - prev_t, apc_pkg::RDAP_WR);
      req_valid = 1'b0;
      settle(2);
      cmp_num(last_t - prev_t, apc_pkg::WR_PRE + apc_pkg::RP_CK);
      cmp_num(aw_count - aw0, apc_pkg::BL / apc_pkg::PREFETCH);
      $display("test auto close spacing done");
      // write recovery before precharge, then precharges one clock apart
      issue(apc_pkg::CMD_WR, 3'h5, 1'b0, 1'b0);
      issue(apc_pkg::CMD_PRE, 3'h5, 1'b0, 1'b0);
      issue(apc_pkg::CMD_PRE, 3'h0, 1'b1, 1'b0);
      cmp_num(last_t - prev_t, apc_pkg::WR_PRE);
      issue(apc_pkg::CMD_PRE, 3'h1, 1'b0, 1'b0);
      req_valid = 1'b0;
      settle(2);
      cmp_num(last_t - prev_t, apc_pkg::PRE_PRE);
      cmp_vec(bank_open, 8'h00);
      // write cut by terminate two clocks in: shorter recovery
      issue(apc_pkg::CMD_ACT, 3'h5, 1'b0, 1'b0);
      issue(apc_pkg::CMD_WR, 3'h5, 1'b0, 1'b0);
      req_valid = 1'b0;
      settle(1);
      issue(apc_pkg::CMD_BST, 3'h5, 1'b0, 1'b0);
      issue(apc_pkg::CMD_PRE, 3'h5, 1'b0, 1'b0);
      req_valid = 1'b0;
      settle(2);
      cmp_num(last_t - prev_t, apc_pkg::BSTW_PRE);
      $display("test write recovery done");
      conclude();
   end
endmodule : apc_tb_top
